// ### design/tmc_config_regs.sv
// Function
// - Bit 7 of the alert qualification register turns the bus time-out on when one and off when zero, reset zero.
// - Bits 3 to 1 set the run of out-of-limit conversions before alert: 0h one, 1h two, 3h three, 7h four.
// - Pointer 23h holds a host read/write two's-complement ideality adjustment from -128 to 127.
// - The ideality adjustment resets to 00h, leaving the trimmed factor 1.008 in force.
// - Remote conversion uses factor 1.008 times 2088 over 2088 plus the signed adjustment.
// - Bits 1 to 0 at 24h pick remote averaging: 0h off, 1h four, 2h eight, others unused.
// - Pointer FEh reads back a fixed maker code and ignores writes.
`timescale 1ns/1ps
`default_nettype none
module tmc_config_regs (
   input  wire logic                           clk_in,
   input  wire logic                           resetn_in,
   input  wire logic [7:0]                     reg_addr_in,
   input  wire logic                           reg_wr_in,
   input  wire logic                           reg_rd_in,
   input  wire logic [7:0]                     reg_wdata_in,
   output logic [7:0]                          reg_rdata_out,
   input  wire logic                           conv_done_in,
   input  wire logic                           out_of_limit_in,
   output logic                                alert_out,
   input  wire logic                           remote_valid_in,
   input  wire logic [tmc_pkg::TMC_SAMPLE_W-1:0] remote_sample_in,
   output logic                                remote_avg_valid_out,
   output logic [tmc_pkg::TMC_SAMPLE_W-1:0]    remote_avg_out,
   output logic                                bus_timeout_enable_out,
   output logic [11:0]                         ideality_denom_out
);
   import tmc_pkg::*;

   logic       bus_timeout_enable_r;
   logic [2:0] consecutive_fault_count_r;
   logic [7:0] ideality_adjust_value_r;
   logic [1:0] remote_average_select_r;
   logic [2:0] run_cnt_r;
   logic [2:0] run_cnt_nxt;
   logic [2:0] run_need;
   logic [7:0] rdata_nxt;
   logic [11:0] denom_nxt;

   // Register writes; reserved bits are not stored
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         bus_timeout_enable_r      <= TMC_ALERT_QUAL_RST[TMC_TOUT_BIT];
         consecutive_fault_count_r <=
            TMC_ALERT_QUAL_RST[TMC_CONSEC_MSB:TMC_CONSEC_LSB];
         ideality_adjust_value_r   <= TMC_IDEALITY_RST;
         remote_average_select_r   <= TMC_FILT_RST;
      end else if (reg_wr_in) begin
         case (reg_addr_in)
            TMC_ADDR_ALERT_QUAL: begin
               bus_timeout_enable_r      <= reg_wdata_in[TMC_TOUT_BIT];
               consecutive_fault_count_r <=
                  reg_wdata_in[TMC_CONSEC_MSB:TMC_CONSEC_LSB];
            end
            TMC_ADDR_IDEALITY: begin
               ideality_adjust_value_r <= reg_wdata_in;
            end
            TMC_ADDR_FILTER: begin
               remote_average_select_r <= reg_wdata_in[TMC_FILT_MSB:0];
            end
            default: begin
               // Maker code and unmapped pointers ignore writes
            end
         endcase
      end
   end

   // Read mux; unmapped pointers read 00h
   always_comb begin
      case (reg_addr_in)
         TMC_ADDR_ALERT_QUAL:
            rdata_nxt = TMC_ALERT_QUAL_FIX
                      | {bus_timeout_enable_r, 3'h0,
                         consecutive_fault_count_r, 1'b0};
         TMC_ADDR_IDEALITY: rdata_nxt = ideality_adjust_value_r;
         TMC_ADDR_FILTER:   rdata_nxt = {6'h00, remote_average_select_r};
         TMC_ADDR_MAKER:    rdata_nxt = TMC_MAKER_CODE;
         default:           rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         reg_rdata_out <= rdata_nxt;
      end
   end

   // Thermometer code: need equals ones count plus one
   always_comb begin
      run_need = 3'h1 + {2'h0, consecutive_fault_count_r[0]}
               + {2'h0, consecutive_fault_count_r[1]}
               + {2'h0, consecutive_fault_count_r[2]};
      if (!out_of_limit_in) begin
         run_cnt_nxt = 3'h0;
      end else if (run_cnt_r < 3'h4) begin
         run_cnt_nxt = run_cnt_r + 3'h1;
      end else begin
         run_cnt_nxt = run_cnt_r;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         run_cnt_r <= 3'h0;
         alert_out <= 1'b0;
      end else if (conv_done_in) begin
         run_cnt_r <= run_cnt_nxt;
         alert_out <= (run_cnt_nxt >= run_need);
      end
   end

   // Sign-extended adjustment added to the fixed base
   assign denom_nxt = TMC_IDEAL_BASE
                    + {{4{ideality_adjust_value_r[7]}},
                       ideality_adjust_value_r};

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ideality_denom_out <= TMC_IDEAL_BASE;
      end else begin
         ideality_denom_out <= denom_nxt;
      end
   end

   assign bus_timeout_enable_out = bus_timeout_enable_r;

   tmc_remote_avg u_avg (
      .clk_in          (clk_in),
      .resetn_in       (resetn_in),
      .avg_sel_in      (remote_average_select_r),
      .sample_valid_in (remote_valid_in),
      .sample_in       (remote_sample_in),
      .avg_valid_out   (remote_avg_valid_out),
      .avg_out         (remote_avg_out)
   );

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   sequence fault_conv_s;
      conv_done_in && out_of_limit_in;
   endsequence
   sequence clear_conv_s;
      conv_done_in && !out_of_limit_in;
   endsequence

   timeout_write_a: assert property (
      reg_wr_in && reg_addr_in == TMC_ADDR_ALERT_QUAL
      |=> bus_timeout_enable_out == $past(reg_wdata_in[TMC_TOUT_BIT]))
      else $error("time-out enable did not follow write");

   single_fault_a: assert property (
      fault_conv_s and (consecutive_fault_count_r == 3'h0) |=> alert_out)
      else $error("alert missing after one fault with count code 0");

   two_fault_a: assert property (
      (fault_conv_s and consecutive_fault_count_r == 3'h1)
      ##1 (!conv_done_in)[*1] ##1
      (fault_conv_s and consecutive_fault_count_r == 3'h1) |=> alert_out)
      else $error("alert missing after two faults with code 1");

   ideality_rw_a: assert property (
      reg_wr_in && reg_addr_in == TMC_ADDR_IDEALITY ##1 !reg_wr_in ##1
      (reg_rd_in && reg_addr_in == TMC_ADDR_IDEALITY && !reg_wr_in)
      |=> reg_rdata_out == $past(reg_wdata_in, 3))
      else $error("ideality readback mismatch");

   ideality_reset_a: assert property (
      $rose(resetn_in) |-> ideality_denom_out == TMC_IDEAL_BASE)
      else $error("ideality denominator not at base after reset");

   denom_calc_a: assert property (
      reg_wr_in && reg_addr_in == TMC_ADDR_IDEALITY ##1 !reg_wr_in
      |=> ideality_denom_out == TMC_IDEAL_BASE
          + {{4{$past(reg_wdata_in[7], 2)}}, $past(reg_wdata_in, 2)})
      else $error("ideality denominator wrong");

   avg_off_a: assert property (
      (remote_valid_in && remote_average_select_r == TMC_AVG_OFF)
      ##1 (remote_average_select_r == TMC_AVG_OFF)
      |=> remote_avg_valid_out
          && remote_avg_out == $past(remote_sample_in, 2))
      else $error("unfiltered remote result wrong");

   maker_read_a: assert property (
      reg_rd_in && reg_addr_in == TMC_ADDR_MAKER
      |=> reg_rdata_out == TMC_MAKER_CODE)
      else $error("maker code read wrong");

   run_restart_a: assert property (
      clear_conv_s ##1 (!conv_done_in)[*1] ##1
      (fault_conv_s and consecutive_fault_count_r != 3'h0) |=> !alert_out)
      else $error("alert after broken run");
endmodule
`default_nettype wire

// ### inc/tmc_pkg.sv
`default_nettype none
package tmc_pkg;
   // Pointer addresses
   localparam logic [7:0] TMC_ADDR_ALERT_QUAL = 8'h22;
   localparam logic [7:0] TMC_ADDR_IDEALITY   = 8'h23;
   localparam logic [7:0] TMC_ADDR_FILTER     = 8'h24;
   localparam logic [7:0] TMC_ADDR_MAKER      = 8'hfe;
   // Alert qualification fields
   localparam int         TMC_TOUT_BIT        = 7;
   localparam int         TMC_CONSEC_LSB      = 1;
   localparam int         TMC_CONSEC_MSB      = 3;
   localparam logic [7:0] TMC_ALERT_QUAL_RST  = 8'h01;
   localparam logic [7:0] TMC_ALERT_QUAL_FIX  = 8'h01;
   // Ideality and filter
   localparam logic [7:0] TMC_IDEALITY_RST    = 8'h00;
   localparam logic [11:0] TMC_IDEAL_BASE     = 12'h828;
   localparam int         TMC_FILT_MSB        = 1;
   localparam logic [1:0] TMC_FILT_RST        = 2'h0;
   // Identity code, value is arbitrary
   localparam logic [7:0] TMC_MAKER_CODE      = 8'h3c;
   localparam int         TMC_SAMPLE_W        = 12;
   localparam int         TMC_HIST_DEPTH      = 8;
   typedef enum logic [1:0] {
      TMC_AVG_OFF = 2'h0,
      TMC_AVG_4   = 2'h1,
      TMC_AVG_8   = 2'h2,
      TMC_AVG_NA  = 2'h3
   } tmc_avg_t;
endpackage
`default_nettype wire

// ### design/tmc_remote_avg.sv
`timescale 1ns/1ps
`default_nettype none
module tmc_remote_avg (
   input  wire logic                           clk_in,
   input  wire logic                           resetn_in,
   input  wire logic [1:0]                     avg_sel_in,
   input  wire logic                           sample_valid_in,
   input  wire logic [tmc_pkg::TMC_SAMPLE_W-1:0] sample_in,
   output logic                                avg_valid_out,
   output logic [tmc_pkg::TMC_SAMPLE_W-1:0]    avg_out
);
   import tmc_pkg::*;

   logic [TMC_SAMPLE_W-1:0] hist_r [TMC_HIST_DEPTH];
   logic                    pend_r;
   logic [TMC_SAMPLE_W+2:0] sum4;
   logic [TMC_SAMPLE_W+2:0] sum8;
   logic [TMC_SAMPLE_W-1:0] avg_nxt;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         hist_r[0] <= '0;
      end else if (sample_valid_in) begin
         hist_r[0] <= sample_in;
      end
   end

   genvar i;
   generate
      for (i = 1; i < TMC_HIST_DEPTH; i++) begin : g_hist
         always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
               hist_r[i] <= '0;
            end else if (sample_valid_in) begin
               hist_r[i] <= hist_r[i-1];
            end
         end
      end
   endgenerate

   // Window starts filled with zeros, so early averages read low
   always_comb begin
      sum4 = '0;
      sum8 = '0;
      for (int k = 0; k < TMC_HIST_DEPTH; k++) begin
         if (k < 4) begin
            sum4 = sum4 + {3'h0, hist_r[k]};
         end
         sum8 = sum8 + {3'h0, hist_r[k]};
      end
      case (tmc_avg_t'(avg_sel_in))
         TMC_AVG_4: avg_nxt = sum4[TMC_SAMPLE_W+1:2];
         TMC_AVG_8: avg_nxt = sum8[TMC_SAMPLE_W+2:3];
         default:   avg_nxt = hist_r[0];
      endcase
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pend_r        <= 1'b0;
         avg_valid_out <= 1'b0;
         avg_out       <= '0;
      end else begin
         pend_r        <= sample_valid_in;
         avg_valid_out <= pend_r;
         if (pend_r) begin
            avg_out <= avg_nxt;
         end
      end
   end
endmodule
`default_nettype wire

// ### dv/tmc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module tmc_host_model (
   input  wire logic       clk_in,
   output logic [7:0]      addr_out,
   output logic            wr_out,
   output logic            rd_out,
   output logic [7:0]      wdata_out,
   input  wire logic [7:0] rdata_in
);
   initial begin
      addr_out  = 8'h00;
      wr_out    = 1'b0;
      rd_out    = 1'b0;
      wdata_out = 8'h00;
   end
   // Released lines flip so a stale value never passes as valid
   task automatic release_bus();
      @(negedge clk_in);
      wr_out    = 1'b0;
      rd_out    = 1'b0;
      addr_out  = ~addr_out;
      wdata_out = ~wdata_out;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_in);
      addr_out  = a;
      wdata_out = d;
      wr_out    = 1'b1;
      release_bus();
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_in);
      addr_out = a;
      rd_out   = 1'b1;
      release_bus();
      @(negedge clk_in);
      d = rdata_in;
   endtask
endmodule
`default_nettype wire

// ### dv/temp_monitor_config_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module temp_monitor_config_regs_tb;
   import tmc_pkg::*;
   typedef struct packed {
      logic [7:0]  a;
      logic [7:0]  w;
      logic [7:0]  r;
      logic [11:0] dn;
   } tmc_row_t;
   tmc_row_t    rows [0:7] = '{
      '{8'h22, 8'hff, 8'h8f, 12'h000}, '{8'h22, 8'h00, 8'h01, 12'h000},
      '{8'h23, 8'h80, 8'h80, 12'h7a8}, '{8'h23, 8'h7f, 8'h7f, 12'h8a7},
      '{8'h23, 8'hf6, 8'hf6, 12'h81e}, '{8'h24, 8'hff, 8'h03, 12'h000},
      '{8'hfe, 8'h00, TMC_MAKER_CODE, 12'h000},
      '{8'h30, 8'h5a, 8'h00, 12'h000}};
   logic [2:0]  codes [4]  = '{3'h0, 3'h1, 3'h3, 3'h7};
   logic [11:0] fv [4]     = '{12'h000, 12'h040, 12'h080, 12'h000};
   logic [11:0] lv [4]     = '{12'h100, 12'h0c0, 12'h180, 12'h123};
   logic [11:0] ev [4]     = '{12'h100, 12'h060, 12'h0a0, 12'h123};
   logic        clk_in     = 1'b0;
   logic        resetn_in  = 1'b0;
   logic        conv_done_in = 1'b0;
   logic        out_of_limit_in = 1'b0;
   logic        remote_valid_in = 1'b0;
   logic [11:0] remote_sample_in = 12'h000;
   logic [7:0]  addr, wdata, rdata, rd;
   logic        wr, rdn, alert_out, avg_vld, tout;
   logic [11:0] avg, denom;
   int          err_count = 0;
   int          compares  = 0;
   always #25 clk_in = ~clk_in;
   tmc_host_model i_host (.clk_in(clk_in), .addr_out(addr), .wr_out(wr),
      .rd_out(rdn), .wdata_out(wdata), .rdata_in(rdata));
   tmc_config_regs i_dut (.clk_in(clk_in), .resetn_in(resetn_in),
      .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rdn),
      .reg_wdata_in(wdata), .reg_rdata_out(rdata),
      .conv_done_in(conv_done_in), .out_of_limit_in(out_of_limit_in),
      .alert_out(alert_out), .remote_valid_in(remote_valid_in),
      .remote_sample_in(remote_sample_in),
      .remote_avg_valid_out(avg_vld), .remote_avg_out(avg),
      .bus_timeout_enable_out(tout), .ideality_denom_out(denom));
   task automatic end_of_test();
      if (err_count == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input string nm, input logic [11:0] got,
                        input logic [11:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      i_host.rd_reg(a, rd);
      check("rdata", {4'h0, rd}, {4'h0, e});
   endtask
   task automatic rst_chk();
      @(negedge clk_in);
      resetn_in = 1'b0;
      repeat (2) @(negedge clk_in);
      resetn_in = 1'b1;
      check("tout", {11'h0, tout}, 12'h0);
      check("alert", {11'h0, alert_out}, 12'h0);
      check("denom", denom, TMC_IDEAL_BASE);
      check("rdata", {4'h0, rdata}, 12'h000);
      check("avg_vld", {11'h0, avg_vld}, 12'h0);
      check("avg", avg, 12'h000);
      rd_chk(TMC_ADDR_ALERT_QUAL, TMC_ALERT_QUAL_RST);
      rd_chk(TMC_ADDR_IDEALITY, TMC_IDEALITY_RST);
      rd_chk(TMC_ADDR_FILTER, 8'h00);
   endtask
   // Stray limit level between conversions must be ignored
   task automatic conv(input logic oor, input logic e);
      @(negedge clk_in);
      conv_done_in    = 1'b1;
      out_of_limit_in = oor;
      @(negedge clk_in);
      conv_done_in    = 1'b0;
      out_of_limit_in = ~oor;
      check("alert", {11'h0, alert_out}, {11'h0, e});
   endtask
   task automatic samp(input logic [11:0] s, input logic chk,
                       input logic [11:0] e);
      @(negedge clk_in);
      if (chk)
         check("avg_vld", {11'h0, avg_vld}, 12'h0);
      remote_valid_in  = 1'b1;
      remote_sample_in = s;
      @(negedge clk_in);
      remote_valid_in  = 1'b0;
      remote_sample_in = ~s;
      @(negedge clk_in);
      if (chk) begin
         check("avg_vld", {11'h0, avg_vld}, 12'h1);
         check("avg", avg, e);
      end
   endtask
   initial begin
      #1_000_000;
      err_count++;
      end_of_test();
   end
   initial begin
      repeat (2) @(negedge clk_in);
      resetn_in = 1'b1;
      rst_chk();
      foreach (rows[i]) begin
         i_host.wr_reg(rows[i].a, rows[i].w);
         rd_chk(rows[i].a, rows[i].r);
         if (rows[i].a == TMC_ADDR_IDEALITY)
            check("denom", denom, rows[i].dn);
         if (rows[i].a == TMC_ADDR_ALERT_QUAL)
            check("tout", {11'h0, tout}, {11'h0, rows[i].w[7]});
      end
      for (int k = 0; k < 4; k++) begin
         i_host.wr_reg(TMC_ADDR_ALERT_QUAL, {4'h0, codes[k], 1'b0});
         for (int n = 0; n < k; n++)
            conv(1'b1, 1'b0);
         conv(1'b0, 1'b0);
         for (int n = 0; n <= k; n++)
            conv(1'b1, n == k);
         conv(1'b0, 1'b0);
      end
      for (int s = 0; s < 4; s++) begin
         i_host.wr_reg(TMC_ADDR_FILTER, 8'(s));
         if (fv[s] !== 12'h000)
            repeat (8) samp(fv[s], 1'b0, 12'h000);
         samp(lv[s], 1'b1, ev[s]);
      end
      // Leave every reset target except the consecutive count, pend_r and avg_vld away from its reset value first
      i_host.wr_reg(TMC_ADDR_ALERT_QUAL, 8'h80);
      conv(1'b1, 1'b1);
      rd_chk(TMC_ADDR_MAKER, TMC_MAKER_CODE);
      rst_chk();
      end_of_test();
   end
endmodule
`default_nettype wire
